/* mac_backoff_pkg.sv */
// How it works
// - back-off exponent is min(retries, ten)
// - LFSR low bits count down per slot
// - limit field caps LFSR bits used
// - one slot is 512 bit times
// - duplex bit manual, or reports detection
// - duplex bit zero half, one full
// - full duplex ignores collisions entirely
// - gigabit speed forces full duplex
// - speed field manual, or reports detection
// - speed codes select 10/100/1000
// - config survives mac soft reset
// - defaults from eeprom, otp, else CFG_DEFAULT (auto duplex on)
// - auto duplex defaults to enabled
// - auto speed defaults to disabled
// - auto speed samples receive clock
package mac_backoff_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] CFG_OFFSET    = 12'h100;
    localparam logic [11:0] STATUS_OFFSET = 12'h180;

    localparam int MAC_RESET_BIT    = 0;
    localparam int SPEED_LSB        = 1;
    localparam int DUPLEX_BIT       = 3;
    localparam int LIMIT_LSB        = 6;
    localparam int AUTO_SPEED_BIT   = 11;
    localparam int AUTO_DUPLEX_BIT  = 12;

    // ****************************************
    // speed codes and field types
    // ****************************************
    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    typedef struct packed {
        logic       autoDuplex;
        logic       autoSpeed;
        logic [1:0] backoffLimit;
        logic       duplex;
        logic [1:0] speed;
    } cfg_s;

    localparam cfg_s CFG_DEFAULT = '{autoDuplex: 1'b1, autoSpeed: 1'b0,
                                     backoffLimit: 2'h0, duplex: 1'b0,
                                     speed: SPEED_10};

    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_PERIOD_PS  = 40000;
    localparam int SLOT_BITS        = 512;
    localparam int BIT_PS_10        = 100000;
    localparam int BIT_PS_100       = 10000;
    localparam int BIT_PS_1000      = 1000;
    localparam logic [10:0] SLOT_CYC_10 =
        11'((SLOT_BITS * BIT_PS_10 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);
    localparam logic [10:0] SLOT_CYC_100 =
        11'((SLOT_BITS * BIT_PS_100 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);
    localparam logic [10:0] SLOT_CYC_1000 =
        11'((SLOT_BITS * BIT_PS_1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);

    localparam logic [4:0] MAX_EXPONENT     = 5'd10;
    localparam logic [2:0] MAC_RESET_CYCLES = 3'd4;
    localparam logic [15:0] LFSR_SEED       = 16'hace1;
    // receive clock divided by 16 for measuring, toggling every 8 edges
    localparam int RX_DIV_BIT               = 3;
    localparam logic [7:0] GIG_LIMIT        = 8'd8;
    localparam logic [7:0] FAST_LIMIT       = 8'd64;

    typedef enum logic [1:0] {BO_IDLE, BO_WAIT, BO_DONE} backoff_e;

endpackage

/* mac_backoff_speed_duplex_ctrl.sv */
`timescale 1ns/1ps
module mac_backoff_speed_duplex_ctrl (
    input  wire logic                   clock,         // system clock
    input  wire logic                   rst,           // sync reset, high
    input  wire logic                   rxClk,         // receive clock from phy
    input  wire logic                   linkDuplexIn,  // phy duplex status pin
    input  wire logic                   psel,          // apb select
    input  wire logic                   penable,       // apb enable
    input  wire logic                   pwrite,        // apb direction
    input  wire logic [11:0]            paddr,         // apb byte address
    input  wire logic [31:0]            pwdata,        // apb write data
    output logic                        pready,        // apb ready
    output logic      [31:0]            prdata,        // apb read data
    output logic                        pslverr,       // apb error
    input  wire logic                   loadImage,     // image load pulse
    input  wire logic                   eepromValid,   // eeprom image present
    input  wire mac_backoff_pkg::cfg_s  eepromCfg,     // eeprom config
    input  wire logic                   otpValid,      // otp programmed
    input  wire mac_backoff_pkg::cfg_s  otpCfg,        // otp config
    input  wire logic                   usbReset,      // usb reset pulse
    input  wire logic                   softLiteReset, // soft lite reset pulse
    input  wire logic                   collision,     // collision pulse
    input  wire logic [4:0]             retryCount,    // retries of frame
    output logic                        backoffBusy,   // waiting out back-off
    output logic                        backoffDone,   // back-off over pulse
    output logic                        fullDuplexOut, // effective duplex
    output logic      [1:0]             speedOut,      // effective speed
    output logic                        macResetOut    // mac logic reset
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic isGig(input logic [1:0] s);
        return s[1];
    endfunction

    function automatic logic [10:0] slotCycles(input logic [1:0] s);
        if (isGig(s)) begin
            return mac_backoff_pkg::SLOT_CYC_1000;
        end else if (s == mac_backoff_pkg::SPEED_100) begin
            return mac_backoff_pkg::SLOT_CYC_100;
        end
        return mac_backoff_pkg::SLOT_CYC_10;
    endfunction

    // ****************************************
    // receive clock domain
    // ****************************************
    typedef struct packed {
        logic       rstMeta;
        logic       rstSync;
        logic [3:0] divCnt;
    } rx_state_s;

    rx_state_s rx_r;
    rx_state_s rx_nxt;

    always_comb begin
        rx_nxt         = rx_r;
        rx_nxt.rstMeta = rst;
        rx_nxt.rstSync = rx_r.rstMeta;
        rx_nxt.divCnt  = rx_r.rstSync ? 4'h0 : rx_r.divCnt + 4'h1;
    end

    always_ff @(posedge rxClk) begin
        rx_r <= rx_nxt;
    end

    // ****************************************
    // system clock domain
    // ****************************************
    typedef struct packed {
        mac_backoff_pkg::cfg_s     image;
        mac_backoff_pkg::cfg_s     cfg;
        logic                      macReset;
        logic [2:0]                resetCnt;
        logic [2:0]                togSync;
        logic [1:0]                dpxSync;
        logic [7:0]                measCnt;
        logic                      detDuplex;
        logic [1:0]                detSpeed;
        logic [15:0]               lfsr;
        mac_backoff_pkg::backoff_e boState;
        logic [9:0]                slotsLeft;
        logic [10:0]               slotCnt;
        logic                      pready;
        logic [31:0]               prdata;
        logic                      pslverr;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    logic       fullDuplex;
    logic [1:0] speedEff;
    logic [4:0] exponent;
    logic [4:0] limitBits;
    logic [4:0] useBits;
    logic [9:0] mask;
    logic [31:0] cfgWord;
    logic [31:0] statusWord;

    always_comb begin
        s_nxt = s_r;

        // effective mode, detection reported in the config fields
        speedEff   = s_r.cfg.speed;
        fullDuplex = s_r.cfg.duplex | isGig(speedEff);

        // back-off exponent and bit cap
        exponent = (retryCount > mac_backoff_pkg::MAX_EXPONENT) ?
                   mac_backoff_pkg::MAX_EXPONENT : retryCount;
        case (s_r.cfg.backoffLimit)
            2'h0:    limitBits = 5'd10;
            2'h1:    limitBits = 5'd8;
            2'h2:    limitBits = 5'd4;
            default: limitBits = 5'd1;
        endcase
        useBits = (exponent < limitBits) ? exponent : limitBits;
        mask    = 10'((11'h1 << useBits) - 11'h1);

        cfgWord = 32'h0;
        cfgWord[mac_backoff_pkg::AUTO_DUPLEX_BIT]  = s_r.cfg.autoDuplex;
        cfgWord[mac_backoff_pkg::AUTO_SPEED_BIT]   = s_r.cfg.autoSpeed;
        cfgWord[mac_backoff_pkg::LIMIT_LSB +: 2]   = s_r.cfg.backoffLimit;
        cfgWord[mac_backoff_pkg::DUPLEX_BIT]       = s_r.cfg.duplex;
        cfgWord[mac_backoff_pkg::SPEED_LSB +: 2]   = s_r.cfg.speed;
        cfgWord[mac_backoff_pkg::MAC_RESET_BIT]    = s_r.macReset;
        statusWord = {16'h0, s_r.slotsLeft, 2'h0, s_r.boState == mac_backoff_pkg::BO_WAIT,
                      fullDuplex, speedEff};

        // free-running lfsr, taps 16 15 13 4
        s_nxt.lfsr = {s_r.lfsr[14:0],
                      s_r.lfsr[15] ^ s_r.lfsr[14] ^ s_r.lfsr[12] ^ s_r.lfsr[3]};

        // receive clock measurement, first flop read only by second
        s_nxt.togSync = {s_r.togSync[1:0], rx_r.divCnt[mac_backoff_pkg::RX_DIV_BIT]};
        s_nxt.dpxSync = {s_r.dpxSync[0], linkDuplexIn};
        s_nxt.detDuplex = s_r.dpxSync[1];
        if (s_r.togSync[2] != s_r.togSync[1]) begin
            s_nxt.measCnt = 8'h0;
            if (s_r.measCnt < mac_backoff_pkg::GIG_LIMIT) begin
                s_nxt.detSpeed = mac_backoff_pkg::SPEED_1000;
            end else if (s_r.measCnt < mac_backoff_pkg::FAST_LIMIT) begin
                s_nxt.detSpeed = mac_backoff_pkg::SPEED_100;
            end else begin
                s_nxt.detSpeed = mac_backoff_pkg::SPEED_10;
            end
        end else if (s_r.measCnt != 8'hff) begin
            s_nxt.measCnt = s_r.measCnt + 8'h1;
        end
        if (s_r.cfg.autoSpeed) begin
            s_nxt.cfg.speed = s_r.detSpeed;
        end
        if (s_r.cfg.autoDuplex) begin
            s_nxt.cfg.duplex = s_r.detDuplex;
        end

        // back-off engine
        case (s_r.boState)
            mac_backoff_pkg::BO_IDLE: begin
                if (collision && !fullDuplex) begin
                    s_nxt.slotsLeft = s_r.lfsr[9:0] & mask;
                    s_nxt.slotCnt   = slotCycles(speedEff);
                    s_nxt.boState   = ((s_r.lfsr[9:0] & mask) == 10'h0) ?
                                      mac_backoff_pkg::BO_DONE : mac_backoff_pkg::BO_WAIT;
                end
            end
            mac_backoff_pkg::BO_WAIT: begin
                if (s_r.slotCnt == 11'h1) begin
                    s_nxt.slotCnt   = slotCycles(speedEff);
                    s_nxt.slotsLeft = s_r.slotsLeft - 10'h1;
                    if (s_r.slotsLeft == 10'h1) begin
                        s_nxt.boState = mac_backoff_pkg::BO_DONE;
                    end
                end else begin
                    s_nxt.slotCnt = s_r.slotCnt - 11'h1;
                end
            end
            default: begin
                s_nxt.boState = mac_backoff_pkg::BO_IDLE;
            end
        endcase

        // mac soft reset, self-clearing
        if (s_r.macReset) begin
            s_nxt.boState = mac_backoff_pkg::BO_IDLE;
            s_nxt.measCnt = 8'h0;
            if (s_r.resetCnt == 3'h1) begin
                s_nxt.macReset = 1'b0;
            end
            s_nxt.resetCnt = s_r.resetCnt - 3'h1;
        end

        // apb slave, answers one cycle into the access phase
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0;
            if (paddr == mac_backoff_pkg::CFG_OFFSET) begin
                if (pwrite) begin
                    s_nxt.cfg.backoffLimit = pwdata[mac_backoff_pkg::LIMIT_LSB +: 2];
                    s_nxt.cfg.autoSpeed    = pwdata[mac_backoff_pkg::AUTO_SPEED_BIT];
                    s_nxt.cfg.autoDuplex   = pwdata[mac_backoff_pkg::AUTO_DUPLEX_BIT];
                    if (!s_r.cfg.autoDuplex) begin
                        s_nxt.cfg.duplex = pwdata[mac_backoff_pkg::DUPLEX_BIT];
                    end
                    if (!s_r.cfg.autoSpeed) begin
                        s_nxt.cfg.speed = pwdata[mac_backoff_pkg::SPEED_LSB +: 2];
                    end
                    if (pwdata[mac_backoff_pkg::MAC_RESET_BIT]) begin
                        s_nxt.macReset = 1'b1;
                        s_nxt.resetCnt = mac_backoff_pkg::MAC_RESET_CYCLES;
                    end
                end else begin
                    s_nxt.prdata = cfgWord;
                end
            end else if (paddr == mac_backoff_pkg::STATUS_OFFSET) begin
                if (!pwrite) begin
                    s_nxt.prdata = statusWord;
                end
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end

        // image load and restoring resets; soft mac reset leaves config
        if (loadImage) begin
            s_nxt.image = eepromValid ? eepromCfg :
                          otpValid ? otpCfg : mac_backoff_pkg::CFG_DEFAULT;
            s_nxt.cfg   = s_nxt.image;
        end else if (usbReset || softLiteReset) begin
            s_nxt.cfg = s_r.image;
        end

        if (rst) begin
            s_nxt           = '0;
            s_nxt.image     = mac_backoff_pkg::CFG_DEFAULT;
            s_nxt.cfg       = mac_backoff_pkg::CFG_DEFAULT;
            s_nxt.lfsr      = mac_backoff_pkg::LFSR_SEED;
            s_nxt.boState   = mac_backoff_pkg::BO_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        s_r <= s_nxt;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pready        = s_r.pready;
    assign prdata        = s_r.prdata;
    assign pslverr       = s_r.pslverr;
    assign backoffBusy   = s_r.boState == mac_backoff_pkg::BO_WAIT;
    assign backoffDone   = s_r.boState == mac_backoff_pkg::BO_DONE;
    assign fullDuplexOut = s_r.cfg.duplex | isGig(s_r.cfg.speed);
    assign speedOut      = s_r.cfg.speed;
    assign macResetOut   = s_r.macReset;

endmodule

/* mac_phy_model.sv */
`timescale 1ns/1ps
module mac_phy_model (
    input  wire logic fullDuplex, // duplex to report
    output logic      rxClk,      // receive clock
    output logic      duplexOut   // duplex status pin
);
    // free-running 80 ns receive clock, phase unrelated
    initial begin
        rxClk = 1'b0;
        #7;
        forever #40 rxClk = ~rxClk;
    end
    assign duplexOut = fullDuplex;
endmodule

/* mac_backoff_chk.sv */
`timescale 1ns/1ps
module mac_backoff_chk (
    input wire logic       clock,         // system clock
    input wire logic       rst,           // sync reset
    input wire logic       psel,          // apb select
    input wire logic       penable,       // apb enable
    input wire logic       pready,        // apb ready
    input wire logic       collision,     // collision pulse
    input wire logic       backoffBusy,   // back-off running
    input wire logic       backoffDone,   // back-off over
    input wire logic       fullDuplexOut, // effective duplex
    input wire logic [1:0] speedOut,      // effective speed
    input wire logic       macResetOut    // mac reset
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ****
    // back-off
    // ****
    sequence s_half;
        collision && !fullDuplexOut && !backoffBusy && !backoffDone && !macResetOut;
    endsequence
    sequence s_full;
        collision && fullDuplexOut && !backoffBusy && !backoffDone;
    endsequence
    property p_start; s_half |=> backoffBusy || backoffDone; endproperty
    a_start: assert property (p_start) else $error("back-off not started");
    property p_full; s_full |=> !backoffBusy && !backoffDone; endproperty
    a_full: assert property (p_full) else $error("full duplex backed off");
    property p_done; backoffDone |=> !backoffDone && !backoffBusy; endproperty
    a_done: assert property (p_done) else $error("done not a pulse");
    property p_end;
        $fell(backoffBusy) |-> backoffDone || macResetOut || $past(macResetOut);
    endproperty
    a_end: assert property (p_end) else $error("busy ended without done");
    property p_slot; $rose(backoffBusy) |-> backoffBusy[*8]; endproperty
    a_slot: assert property (p_slot) else $error("slot too short");
    // ****
    // mode and control
    // ****
    property p_gig; speedOut[1] |-> fullDuplexOut; endproperty
    a_gig: assert property (p_gig) else $error("half duplex at gigabit");
    property p_mac_soft_reset; $rose(macResetOut) |-> macResetOut[*4] ##1 !macResetOut; endproperty
    a_mac_soft_reset: assert property (p_mac_soft_reset) else $error("soft reset length");
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("apb answer late");
endmodule

/* mac_backoff_speed_duplex_ctrl_tb_top.sv */
`timescale 1ns/1ps
module mac_backoff_speed_duplex_ctrl_tb_top;
    localparam logic [11:0] CFG = mac_backoff_pkg::CFG_OFFSET;
    logic                  clock, rst, rxClk, linkDuplexIn, phyFull, psel, penable;
    logic                  pwrite, pready, pslverr, eepromValid, otpValid, collision;
    logic                  backoffBusy, backoffDone, fullDuplexOut, macResetOut, err;
    logic                  sawRst;
    wire                   loadImage, usbReset, softLiteReset;
    logic [1:0]            speedOut;
    logic [2:0]            pul;
    logic [4:0]            retryCount;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, q;
    mac_backoff_pkg::cfg_s eepromCfg, otpCfg;
    int                    mismatches = 0, compares = 0, cyc = 0;

    assign {softLiteReset, usbReset, loadImage} = pul;
    mac_backoff_speed_duplex_ctrl dut_u (.*);
    mac_phy_model phy_u (.fullDuplex(phyFull), .rxClk(rxClk), .duplexOut(linkDuplexIn));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (macResetOut === 1'b1) sawRst <= 1'b1;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [31:0] e);
        apb(1'b0, CFG, 32'h0);
        chk(q, e);
    endtask
    task automatic pulse(input int i);
        pul[i] <= 1'b1;
        @(posedge clock);
        pul <= 3'h0;
        @(posedge clock);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_manual();
        logic [1:0] s;
        for (int i = 0; i < 6; i++) begin
            s = 2'(i % 3);
            apb(1'b1, CFG, {28'h0, i[0], s, 1'b0});
            chk({30'h0, speedOut}, {30'h0, s});
            chk({31'h0, fullDuplexOut}, {31'h0, i[0] | s[1]});
        end
        apb(1'b0, 12'h004, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_image();
        eepromCfg <= '{1'b0, 1'b0, 2'h2, 1'b1, 2'h1};
        otpCfg <= '{1'b0, 1'b0, 2'h1, 1'b0, 2'h2};
        eepromValid <= 1'b1;
        otpValid <= 1'b1;
        pulse(0);
        rd(32'h008a);
        apb(1'b1, CFG, 32'h0);
        pulse(1);
        rd(32'h008a);
        eepromValid <= 1'b0;
        pulse(0);
        apb(1'b1, CFG, 32'h0);
        pulse(2);
        rd(32'h0044);
        otpValid <= 1'b0;
        pulse(0);
        rd(32'h1000);
    endtask
    task automatic t_backoff();
        int rt[4] = '{1, 15, 3, 0};
        int mx[4] = '{1, 15, 7, 0};
        int n, k;
        logic ok;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, CFG, (i == 4) ? 32'h4 : 32'((3 - i) * 64 + 2));
            retryCount <= 5'(rt[i % 4]);
            collision <= 1'b1;
            @(posedge clock);
            collision <= 1'b0;
            n = 0;
            ok = 1'b0;
            do begin
                @(posedge clock);
                n++;
                ok = ok | backoffBusy | backoffDone;
            end while (backoffDone !== 1'b1 && n < ((i == 4) ? 20 : 3000));
            k = (n + 64) / 128;
            if (i == 4) chk({31'h0, ok}, 32'h0);
            else chk({31'h0, k <= mx[i] && n + 2 >= k * 128 && n <= k * 128 + 2}, 32'h1);
        end
    endtask
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, eepromValid, otpValid, collision, phyFull, sawRst} = 8'h0;
        {paddr, pwdata, pul, retryCount} = 52'h0;
        eepromCfg = '0;
        otpCfg = '0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(32'h1000);
        chk({29'h0, fullDuplexOut, speedOut}, 32'h0);
        t_manual();
        apb(1'b1, CFG, 32'h0086);
        apb(1'b1, CFG, 32'h0087);
        repeat (10) @(posedge clock);
        rd(32'h0086);
        chk({31'h0, sawRst}, 32'h1);
        t_image();
        t_backoff();
        apb(1'b1, CFG, 32'h0);
        apb(1'b1, CFG, 32'h1008);
        apb(1'b1, CFG, 32'h1008);
        repeat (20) @(posedge clock);
        rd(32'h1000);
        phyFull <= 1'b1;
        repeat (20) @(posedge clock);
        rd(32'h1008);
        apb(1'b1, CFG, 32'h1800);
        repeat (300) @(posedge clock);
        apb(1'b1, CFG, 32'h1804);
        rd(32'h180a);
        chk({30'h0, speedOut}, 32'h1);
        stop_test();
    end
    task automatic stop_test();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
endmodule
bind mac_backoff_speed_duplex_ctrl mac_backoff_chk chk_u (.*);
